// >>> hdl/gdfs_pkg.sv
// Function
// R01: FET drop event needs deglitched over-threshold enabled FET
// R02: pin variant: retry 4 ms, off when tied
// R03: serial two-bit select: latch, retry, report, off
// R04: latch/retry FET event: FETs off, indicator, flags
// R05: latched: resume after condition gone and clear
// R06: retry: auto resume, flags held until period ends
// R07: report only: drivers run, indicator low, clear-released
// R08: shunt event needs deglitched over-threshold sense input
// R09: pin variant shunt: 1 V, retry 4 ms
// R10: shunt latched: FETs off, flags, clear to recover
// R11: shunt retry: FETs off, flags, auto resume
// R12: shunt report only: drivers run, clear-released
// R13: shunt ignored when select off or disabled
// R14: gate fault when gate fails to follow in time
// R15: gate fault: FETs off, flags, clear to recover
// R16: gate-fault disable suppresses detection and response
// R17: thermal warning flag only, clears by itself
// R18: warning report setting also pulls indicator low
// R19: thermal shutdown: all off, auto resume, flag latched
// R20: enable low: sleep after delay, wake on high
// R21: indicator held low briefly while regulators switch
// R22: controller waits wake delay before driving inputs
// R23: enable high-low-high within window clears faults
// R24: indicator low while any source still reporting
package gdfs_pkg;
    localparam int CLK_MHZ = 100;

    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] CMD_OFFSET    = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

    localparam int CTRL_MODE_LSB      = 0;
    localparam int CTRL_DEG_LSB       = 2;
    localparam int CTRL_SHUNT_DIS_BIT = 4;
    localparam int CTRL_GATE_DIS_BIT  = 5;
    localparam int CTRL_WARN_REP_BIT  = 6;
    localparam int CTRL_WIDTH         = 7;
    localparam int CMD_CLEAR_BIT      = 0;

    localparam int ST_FAULT_BIT   = 0;
    localparam int ST_FETDROP_BIT = 1;
    localparam int ST_SHUNT_BIT   = 2;
    localparam int ST_GDF_BIT     = 3;
    localparam int ST_OTW_BIT     = 4;
    localparam int ST_TSD_BIT     = 5;
    localparam int ST_PIN_BIT     = 6;
    localparam int ST_PERFET_LSB  = 7;
    localparam int ST_PERGATE_LSB = 13;
    localparam int ST_STATE_LSB   = 19;
    localparam int ST_SENSE_BIT   = 21;

    localparam int NUM_FETS = 6;

    localparam int DEG_PIN_NS  = 4000;
    localparam int DEG_SEL0_NS = 2000;
    localparam int DEG_SEL1_NS = 4000;
    localparam int DEG_SEL2_NS = 6000;
    localparam int DEG_SEL3_NS = 8000;
    localparam int DEG_W       = 12;

    localparam int RETRY_MS       = 4;
    localparam int RETRY_CYC_DEF  = RETRY_MS * 1000 * CLK_MHZ;
    localparam int WAKE_US        = 1000;
    localparam int WAKE_CYC_DEF   = WAKE_US * CLK_MHZ;
    localparam int DOZE_US        = 1000;
    localparam int DOZE_CYC_DEF   = DOZE_US * CLK_MHZ;
    localparam int GATE_DRIVE_NS  = 4000;
    localparam int GATE_DRIVE_CYC = (GATE_DRIVE_NS * CLK_MHZ + 999) / 1000;
    localparam int REG_SWITCH_NS  = 160;
    localparam int REG_SWITCH_CYC = (REG_SWITCH_NS * CLK_MHZ) / 1000;
    localparam int LONG_W         = 24;
    localparam int GD_W           = 10;

    typedef enum logic [1:0] {
        OCP_LATCH  = 2'b00,
        OCP_RETRY  = 2'b01,
        OCP_REPORT = 2'b10,
        OCP_OFF    = 2'b11
    } gdfs_overcurrent_response_select_type;

    typedef enum logic [1:0] {
        PW_SLEEP = 2'b00,
        PW_WAKE  = 2'b01,
        PW_RUN   = 2'b11,
        PW_DOWN  = 2'b10
    } gdfs_pwr_state_type;
endpackage : gdfs_pkg

// >>> hdl/gdfs_top.sv
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module gdfs_top
    import gdfs_pkg::*;
#(
    parameter int RETRY_CYCLES = RETRY_CYC_DEF,
    parameter int WAKE_CYCLES  = WAKE_CYC_DEF,
    parameter int DOZE_CYCLES  = DOZE_CYC_DEF
)(
    input  wire logic                CLOCK,
    input  wire logic                RST,
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [7:0]          PADDR,
    input  wire logic [31:0]         PWDATA,
    output logic [31:0]              PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    input  wire logic                ENABLE,
    input  wire logic                PIN_CONFIG_MODE,
    input  wire logic                THRESHOLD_PIN_AT_SUPPLY,
    input  wire logic [NUM_FETS-1:0] FET_ON_CMD,
    input  wire logic [NUM_FETS-1:0] FET_DROP_OVER,
    input  wire logic                SHUNT_SENSE_INPUT_OVER,
    input  wire logic [NUM_FETS-1:0] GATE_SENSED_HIGH,
    input  wire logic                THERMAL_WARNING,
    input  wire logic                THERMAL_SHUTDOWN,
    output logic [NUM_FETS-1:0]      GATE_OUT,
    output logic                     CHARGE_PUMP_EN,
    output logic                     REGULATOR_EN,
    output logic                     SERIAL_PORT_EN,
    input  wire logic                FAULT_INDICATOR_N_I,
    output logic                     FAULT_INDICATOR_N_O,
    output logic                     FAULT_INDICATOR_N_OEN
);
    if (RETRY_CYCLES < 16 || RETRY_CYCLES >= 2**LONG_W || WAKE_CYCLES < 1 ||
        WAKE_CYCLES >= 2**LONG_W || DOZE_CYCLES < REG_SWITCH_CYC + 2 ||
        DOZE_CYCLES >= 2**LONG_W) begin : g_bad_param
        $error("gdfs_top: timing parameter out of range");
    end

    function automatic logic [DEG_W-1:0] deg_cycles(input logic [1:0] sel,
                                                    input logic pin_cfg);
        int ns;
        ns = DEG_SEL0_NS;
        if (pin_cfg)
            ns = DEG_PIN_NS;
        else if (sel == 2'd1)
            ns = DEG_SEL1_NS;
        else if (sel == 2'd2)
            ns = DEG_SEL2_NS;
        else if (sel == 2'd3)
            ns = DEG_SEL3_NS;
        return DEG_W'((ns * CLK_MHZ + 999) / 1000);
    endfunction : deg_cycles

    function automatic logic [DEG_W-1:0] deg_step(input logic cond,
                                                  input logic [DEG_W-1:0] cnt,
                                                  input logic [DEG_W-1:0] lim);
        if (!cond)
            return '0;
        if (cnt > lim)
            return cnt;
        return DEG_W'(cnt + 1'b1);
    endfunction : deg_step

    logic [CTRL_WIDTH-1:0] ctrl_reg;
    logic [31:0]           prdata_reg;
    gdfs_pwr_state_type    state_reg;
    logic [LONG_W-1:0]     pw_cnt_reg;
    logic                  rst_pulse;
    logic [DEG_W-1:0]      fet_cnt_reg, sh_cnt_reg;
    logic [LONG_W-1:0]     retry_cnt_reg;
    logic                  retry_busy_reg;
    logic                  fd_flag_reg, fd_report_reg, fd_shut_reg, fd_retry_reg;
    logic [NUM_FETS-1:0]   per_fet_reg;
    logic                  sh_flag_reg, sh_report_reg, sh_shut_reg, sh_retry_reg;
    logic                  sh_sense_reg;
    logic [GD_W-1:0]       gd_cnt_reg [NUM_FETS];
    logic [NUM_FETS-1:0]   per_gate_reg;
    logic                  gdf_flag_reg, gdf_act_reg;
    logic                  otw_reg, tsd_act_reg, tsd_flag_reg;
    logic [NUM_FETS-1:0]   gate_out_reg;
    logic                  cp_en_reg, reg_en_reg, ind_low_reg;

    gdfs_overcurrent_response_select_type fd_mode, sh_mode;
    logic [DEG_W-1:0]  deg_lim;
    logic              fet_cond, sh_cond, fd_event, sh_event, retry_done;
    logic [NUM_FETS-1:0] gd_mismatch, gd_hit;
    logic              gdf_event, gdf_off, shut, ind_low_next, clear_req, asleep;
    logic              setup, access, hit, wr_ok, fault_any;

    assign asleep = (state_reg == PW_SLEEP);

    // register bus: read data captured in setup, so no wait states
    assign setup   = PSEL && !PENABLE;
    assign access  = PSEL && PENABLE;
    assign hit     = (PADDR == CTRL_OFFSET) || (PADDR == CMD_OFFSET) ||
                     (PADDR == STATUS_OFFSET);
    assign wr_ok   = access && PWRITE && hit && !asleep;
    assign PREADY  = 1'b1;
    assign PSLVERR = access && !hit;
    assign PRDATA  = prdata_reg;
    assign clear_req = (wr_ok && PADDR == CMD_OFFSET && PWDATA[CMD_CLEAR_BIT])
                     || rst_pulse; // R23
    assign fault_any = fd_flag_reg || sh_flag_reg || gdf_flag_reg || tsd_flag_reg ||
                       tsd_act_reg;

    always_ff @(posedge CLOCK)
    begin
        if (RST || asleep)
            ctrl_reg <= CTRL_WIDTH'(CTRL_RESET);
        else if (wr_ok && PADDR == CTRL_OFFSET)
            ctrl_reg <= PWDATA[CTRL_WIDTH-1:0];
    end

    // serial port is off in sleep: reads give zero
    always_ff @(posedge CLOCK)
    begin
        if (RST)
            prdata_reg <= 32'h0000_0000;
        else if (setup)
        begin
            prdata_reg <= 32'h0000_0000;
            if (!asleep && PADDR == CTRL_OFFSET)
                prdata_reg[CTRL_WIDTH-1:0] <= ctrl_reg;
            else if (!asleep && PADDR == STATUS_OFFSET)
            begin
                prdata_reg[ST_FAULT_BIT]   <= fault_any;
                prdata_reg[ST_FETDROP_BIT] <= fd_flag_reg;
                prdata_reg[ST_SHUNT_BIT]   <= sh_flag_reg;
                prdata_reg[ST_GDF_BIT]     <= gdf_flag_reg;
                prdata_reg[ST_OTW_BIT]     <= otw_reg;
                prdata_reg[ST_TSD_BIT]     <= tsd_flag_reg;
                prdata_reg[ST_PIN_BIT]     <= FAULT_INDICATOR_N_I;
                prdata_reg[ST_PERFET_LSB +: NUM_FETS]  <= per_fet_reg;
                prdata_reg[ST_PERGATE_LSB +: NUM_FETS] <= per_gate_reg;
                prdata_reg[ST_STATE_LSB +: 2]          <= state_reg;
                prdata_reg[ST_SENSE_BIT]   <= sh_sense_reg;
            end
        end
    end

    // enable low shorter than the doze delay less the regulator switch time is a clear pulse, longer is sleep
    assign rst_pulse = (state_reg == PW_RUN) && ENABLE && (pw_cnt_reg != '0); // R23

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            state_reg  <= PW_SLEEP;
            pw_cnt_reg <= '0;
        end
        else
        begin
            unique case (state_reg)
                PW_SLEEP:
                    if (ENABLE) // R20
                    begin
                        state_reg  <= PW_WAKE;
                        pw_cnt_reg <= LONG_W'(WAKE_CYCLES - 1);
                    end
                PW_WAKE:
                    if (!ENABLE)
                    begin
                        state_reg  <= PW_DOWN;
                        pw_cnt_reg <= LONG_W'(REG_SWITCH_CYC - 1);
                    end
                    else if (pw_cnt_reg == '0)
                        state_reg <= PW_RUN; // R22
                    else
                        pw_cnt_reg <= pw_cnt_reg - 1'b1;
                PW_RUN:
                    if (ENABLE)
                        pw_cnt_reg <= '0;
                    else if (pw_cnt_reg == LONG_W'(DOZE_CYCLES - REG_SWITCH_CYC - 1))
                    begin
                        state_reg  <= PW_DOWN; // R20
                        pw_cnt_reg <= LONG_W'(REG_SWITCH_CYC - 1);
                    end
                    else
                        pw_cnt_reg <= pw_cnt_reg + 1'b1;
                PW_DOWN:
                    if (pw_cnt_reg == '0)
                        state_reg <= PW_SLEEP;
                    else
                        pw_cnt_reg <= pw_cnt_reg - 1'b1;
            endcase
        end
    end

    // pin variant: retry only, FET drop off when threshold pin on supply
    always_comb
    begin
        if (PIN_CONFIG_MODE)
        begin
            fd_mode = THRESHOLD_PIN_AT_SUPPLY ? OCP_OFF : OCP_RETRY; // R02
            sh_mode = OCP_RETRY; // R09
        end
        else
        begin
            fd_mode = gdfs_overcurrent_response_select_type'(ctrl_reg[CTRL_MODE_LSB +: 2]); // R03
            sh_mode = ctrl_reg[CTRL_SHUNT_DIS_BIT] ? OCP_OFF : fd_mode; // R13
        end
    end

    assign deg_lim  = deg_cycles(ctrl_reg[CTRL_DEG_LSB +: 2], PIN_CONFIG_MODE);
    assign fet_cond = |(FET_DROP_OVER & gate_out_reg); // R01
    assign sh_cond  = SHUNT_SENSE_INPUT_OVER;
    assign fd_event = fet_cond && fet_cnt_reg == deg_lim && fd_mode != OCP_OFF; // R01
    assign sh_event = sh_cond && sh_cnt_reg == deg_lim && sh_mode != OCP_OFF; // R08 R13

    always_ff @(posedge CLOCK)
    begin
        if (RST || asleep)
        begin
            fet_cnt_reg <= '0;
            sh_cnt_reg  <= '0;
        end
        else
        begin
            fet_cnt_reg <= deg_step(fet_cond, fet_cnt_reg, deg_lim);
            sh_cnt_reg  <= deg_step(sh_cond, sh_cnt_reg, deg_lim);
        end
    end

    // one retry timer shared by both overcurrent sources
    assign retry_done = retry_busy_reg && retry_cnt_reg == '0;

    always_ff @(posedge CLOCK)
    begin
        if (RST || asleep)
        begin
            retry_busy_reg <= 1'b0;
            retry_cnt_reg  <= '0;
        end
        else if ((fd_event && fd_mode == OCP_RETRY) || (sh_event && sh_mode == OCP_RETRY))
        begin
            retry_busy_reg <= 1'b1;
            retry_cnt_reg  <= LONG_W'(RETRY_CYCLES - 1);
        end
        else if (retry_done)
            retry_busy_reg <= 1'b0;
        else if (retry_busy_reg)
            retry_cnt_reg <= retry_cnt_reg - 1'b1;
    end

    // new event applied last so it wins over a clear in the same cycle
    always_ff @(posedge CLOCK)
    begin
        if (RST || asleep)
        begin
            {fd_flag_reg, fd_report_reg, fd_shut_reg, fd_retry_reg} <= 4'h0;
            per_fet_reg <= '0;
        end
        else
        begin
            if (fd_retry_reg && retry_done) // R06
            begin
                {fd_flag_reg, fd_report_reg, fd_shut_reg, fd_retry_reg} <= 4'h0;
                per_fet_reg <= '0;
            end
            else if (!fd_retry_reg && clear_req && !fet_cond) // R05 R07
            begin
                {fd_flag_reg, fd_report_reg, fd_shut_reg} <= 3'h0;
                per_fet_reg <= '0;
            end
            if (fd_event) // R04
            begin
                fd_flag_reg   <= 1'b1;
                fd_report_reg <= 1'b1;
                per_fet_reg   <= per_fet_reg | (FET_DROP_OVER & gate_out_reg);
                fd_shut_reg   <= (fd_mode != OCP_REPORT); // R07
                fd_retry_reg  <= (fd_mode == OCP_RETRY);
            end
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST || asleep)
            {sh_flag_reg, sh_report_reg, sh_shut_reg, sh_retry_reg, sh_sense_reg} <= 5'h00;
        else
        begin
            if (sh_retry_reg && retry_done) // R11
                {sh_flag_reg, sh_report_reg, sh_shut_reg, sh_retry_reg, sh_sense_reg} <= 5'h00;
            else if (!sh_retry_reg && clear_req && !sh_cond) // R10 R12
                {sh_flag_reg, sh_report_reg, sh_shut_reg} <= 3'h0;
            if (sh_event)
            begin
                sh_flag_reg   <= 1'b1;
                sh_report_reg <= 1'b1;
                sh_shut_reg   <= (sh_mode != OCP_REPORT); // R10 R12
                sh_retry_reg  <= (sh_mode == OCP_RETRY); // R11
                sh_sense_reg  <= (sh_mode == OCP_RETRY);
            end
        end
    end

    // gate must follow its own driven command within the drive time
    assign gdf_off     = !PIN_CONFIG_MODE && ctrl_reg[CTRL_GATE_DIS_BIT]; // R16
    assign gd_mismatch = gate_out_reg ^ GATE_SENSED_HIGH;

    always_comb
    begin
        for (int i = 0; i < NUM_FETS; i++)
            gd_hit[i] = gd_mismatch[i] && gd_cnt_reg[i] == GD_W'(GATE_DRIVE_CYC); // R14
    end
    assign gdf_event = |gd_hit && !gdf_off; // R16

    always_ff @(posedge CLOCK)
    begin
        for (int i = 0; i < NUM_FETS; i++)
        begin
            if (RST || asleep || !gd_mismatch[i])
                gd_cnt_reg[i] <= '0;
            else if (gd_cnt_reg[i] <= GD_W'(GATE_DRIVE_CYC))
                gd_cnt_reg[i] <= gd_cnt_reg[i] + 1'b1;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST || asleep)
        begin
            gdf_flag_reg <= 1'b0;
            gdf_act_reg  <= 1'b0;
            per_gate_reg <= '0;
        end
        else
        begin
            if (gdf_off || (clear_req && gd_mismatch == '0)) // R15
            begin
                gdf_flag_reg <= 1'b0;
                gdf_act_reg  <= 1'b0;
                per_gate_reg <= '0;
            end
            if (gdf_event) // R15
            begin
                gdf_flag_reg <= 1'b1;
                gdf_act_reg  <= 1'b1;
                per_gate_reg <= per_gate_reg | gd_hit;
            end
        end
    end

    // thermal inputs arrive with hysteresis already applied
    always_ff @(posedge CLOCK)
    begin
        if (RST || asleep)
        begin
            otw_reg      <= 1'b0;
            tsd_act_reg  <= 1'b0;
            tsd_flag_reg <= 1'b0;
        end
        else
        begin
            otw_reg     <= THERMAL_WARNING; // R17
            tsd_act_reg <= THERMAL_SHUTDOWN; // R19
            if (clear_req && !THERMAL_SHUTDOWN)
                tsd_flag_reg <= 1'b0;
            if (THERMAL_SHUTDOWN) // R19
                tsd_flag_reg <= 1'b1;
        end
    end

    assign shut = fd_shut_reg || sh_shut_reg || gdf_act_reg || tsd_act_reg ||
                  state_reg != PW_RUN; // R04 R10 R15 R19 R20
    assign ind_low_next = fd_report_reg || sh_report_reg || gdf_act_reg || tsd_act_reg ||
                          (otw_reg && ctrl_reg[CTRL_WARN_REP_BIT]) || // R18
                          state_reg == PW_WAKE || state_reg == PW_DOWN; // R21 R24

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            gate_out_reg <= '0;
            cp_en_reg    <= 1'b0;
            reg_en_reg   <= 1'b0;
            ind_low_reg  <= 1'b0;
        end
        else
        begin
            gate_out_reg <= shut ? '0 : FET_ON_CMD; // R07 R12
            cp_en_reg    <= !asleep && state_reg != PW_DOWN && !tsd_act_reg; // R19 R20
            reg_en_reg   <= !asleep; // R20
            ind_low_reg  <= ind_low_next; // R24
        end
    end

    assign GATE_OUT              = gate_out_reg;
    assign CHARGE_PUMP_EN        = cp_en_reg;
    assign REGULATOR_EN          = reg_en_reg;
    assign SERIAL_PORT_EN        = reg_en_reg;
    assign FAULT_INDICATOR_N_O   = 1'b0;
    assign FAULT_INDICATOR_N_OEN = !ind_low_reg;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    deglitch_held_a: assert property (fd_event |-> fet_cond && $past(fet_cond)) // R01
        else $error("fet drop event without held condition");
    fet_latch_off_a: assert property (fd_event && fd_mode == OCP_LATCH |-> ##2 GATE_OUT == '0) // R04
        else $error("fets not off after latched fet drop event");
    latch_hold_a: assert property (fd_shut_reg && !fd_retry_reg && !clear_req && !asleep |=>
                                   fd_shut_reg) // R05
        else $error("latched shutdown released without clear");
    retry_end_a: assert property (retry_done && !fd_event && !sh_event |=>
                                  !fd_retry_reg && !sh_retry_reg) // R06
        else $error("retry flags not released at period end");
    report_run_a: assert property (fd_event && fd_mode == OCP_REPORT && !fd_shut_reg |=>
                                   fd_report_reg && !fd_shut_reg ##1 !FAULT_INDICATOR_N_OEN) // R07
        else $error("report only mode misbehaved");
    shunt_off_a: assert property (!sh_flag_reg && !PIN_CONFIG_MODE &&
                                  (ctrl_reg[CTRL_SHUNT_DIS_BIT] ||
                                   ctrl_reg[CTRL_MODE_LSB +: 2] == 2'b11) |=> !sh_flag_reg) // R13
        else $error("shunt flag set while disabled");
    gate_dis_a: assert property (gdf_off |=> !gdf_act_reg) // R16
        else $error("gate fault active while disabled");
    warn_report_a: assert property (otw_reg && ctrl_reg[CTRL_WARN_REP_BIT] |=>
                                    !FAULT_INDICATOR_N_OEN) // R18
        else $error("warning not reported on indicator");
    tsd_off_a: assert property (THERMAL_SHUTDOWN |-> ##2 GATE_OUT == '0 && !CHARGE_PUMP_EN) // R19
        else $error("thermal shutdown did not disable outputs");
    wake_hold_a: assert property (state_reg == PW_WAKE |=> !FAULT_INDICATOR_N_OEN) // R21
        else $error("indicator released during wake");
    sleep_regs_a: assert property (asleep ##1 asleep |-> !REGULATOR_EN && GATE_OUT == '0) // R20
        else $error("regulator or gates on in sleep");

    retry_cycle_c: cover property (fd_event && fd_mode == OCP_RETRY ##[1:1000] retry_done);
    pulse_clear_c: cover property (fd_flag_reg && rst_pulse);
    gdf_seen_c:    cover property (gdf_event);
    sleep_wake_c:  cover property (state_reg == PW_DOWN ##[1:1000] state_reg == PW_WAKE);
endmodule : gdfs_top
`default_nettype wire

// >>> verification/gdfs_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module gdfs_ctrl_model
    import gdfs_pkg::*;
#(
    parameter int WAKE_WAIT = 24,
    parameter int PULSE_LOW = 5
)(
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic                go,
    input  wire logic                pulse,
    output logic                     enable,
    output logic                     ready,
    output logic [NUM_FETS-1:0]      fet_on_cmd
);
    int wait_reg;
    int low_reg;

    // a low pulse kept short, or the device would head for sleep
    always_ff @(posedge clock)
    begin
        if (rst || !go)
        begin
            ready    <= 1'b0;
            wait_reg <= WAKE_WAIT;
            low_reg  <= 0;
        end
        else if (pulse && ready)
            low_reg <= PULSE_LOW;
        else if (low_reg != 0)
            low_reg <= low_reg - 1;
        else if (wait_reg != 0)
            wait_reg <= wait_reg - 1;
        else
            ready <= 1'b1;
    end

    always_ff @(posedge clock)
        enable <= !rst && go && !(pulse && ready) && low_reg <= 1;

    assign fet_on_cmd = ready ? 6'h3f : 6'h00;
endmodule : gdfs_ctrl_model
`default_nettype wire

// >>> verification/gate_driver_fault_supervisor_test.sv
`timescale 1ns/100ps
`default_nettype none
module gate_driver_fault_supervisor_test
    import gdfs_pkg::*;
;
    localparam int RETRY = 64;
    localparam int DOZE  = 40;
    logic        clock, rst, psel, penable, pwrite, pin_cfg, tied, sh_over, warn, thermal_shutdown_flag;
    logic        go, pulse, ready, enable, pready, pslverr, slv, cp_en, reg_en, sp_en;
    logic        ind_i, ind_o, ind_oen;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [5:0]  fet_cmd, fet_over, sensed, stuck, gate_out;
    // mode | src,shunt_dis,pin,tied | -,gates_off,ind_low,held
    logic [11:0] rows [13] = '{12'h007, 12'h106, 12'h203, 12'h300, 12'h087, 12'h186,
        12'h283, 12'h380, 12'h0c0, 12'h026, 12'h0a6, 12'h030, 12'h0b6};
    int          err_total, n_checks;

    gdfs_top #(.RETRY_CYCLES(RETRY), .WAKE_CYCLES(20), .DOZE_CYCLES(DOZE)) dut (
        .CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .ENABLE(enable), .PIN_CONFIG_MODE(pin_cfg), .THRESHOLD_PIN_AT_SUPPLY(tied),
        .FET_ON_CMD(fet_cmd), .FET_DROP_OVER(fet_over), .SHUNT_SENSE_INPUT_OVER(sh_over),
        .GATE_SENSED_HIGH(sensed), .THERMAL_WARNING(warn), .THERMAL_SHUTDOWN(thermal_shutdown_flag),
        .GATE_OUT(gate_out), .CHARGE_PUMP_EN(cp_en), .REGULATOR_EN(reg_en),
        .SERIAL_PORT_EN(sp_en), .FAULT_INDICATOR_N_I(ind_i), .FAULT_INDICATOR_N_O(ind_o),
        .FAULT_INDICATOR_N_OEN(ind_oen));
    gdfs_ctrl_model ctrl (.clock(clock), .rst(rst), .go(go), .pulse(pulse),
        .enable(enable), .ready(ready), .fet_on_cmd(fet_cmd));

    // open-drain pin with pull-up
    assign ind_i = ind_oen ? 1'b1 : ind_o;
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // gates follow their drive one cycle late unless stuck
    always @(posedge clock) sensed <= gate_out & ~stuck;

    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cyc(input int c);
        repeat (c) @(posedge clock);
    endtask : cyc
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 20);
        {q, slv} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
        err_total += int'(k >= 20);
        if (k >= 20)
            finish_test;
        @(posedge clock);
    endtask : apb
    task automatic wait_ready;
        int k;
        for (k = 0; k < 100 && ready !== 1'b1; k++) @(posedge clock);
        if (ready !== 1'b1)
        begin
            err_total++;
            finish_test;
        end
        cyc(2);
    endtask : wait_ready

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, pin_cfg, tied, sh_over} = '0;
        {warn, thermal_shutdown_flag, go, pulse, fet_over, stuck, err_total, n_checks} = '0;
        rst = 1'b1;
        cyc(3);
        chk("reset gates", 0, {cp_en, gate_out});
        {rst, go} <= 2'h1;
        cyc(8);
        chk("wake ind", 0, ind_oen);
        wait_ready;
        chk("run", 8'hff, {reg_en, cp_en, gate_out});
        foreach (rows[i])
        begin
            {pin_cfg, tied} <= rows[i][5:4];
            apb(1'b1, CTRL_OFFSET, {27'h0, rows[i][6], 2'h1, rows[i][9:8]});
            {sh_over, fet_over} <= {rows[i][7], 5'h0, !rows[i][7]};
            cyc(395);
            chk("deglitch", 1, ind_oen);
            cyc(15);
            chk("gates", rows[i][2] ? 6'h0 : 6'h3f, gate_out);
            chk("ind", !rows[i][1], ind_oen);
            {sh_over, fet_over} <= '0;
            apb(1'b0, STATUS_OFFSET, 0);
            chk("fault flag", rows[i][1], q[ST_FAULT_BIT]);
            cyc(RETRY + 20);
            chk("ind held", !rows[i][0], ind_oen);
            apb(1'b1, CMD_OFFSET, 32'h1);
            cyc(3);
            chk("clear", 7'h7f, {ind_oen, gate_out});
            $display("row %0d done", i);
        end
        // back to the serial variant, or the gate-fault disable bit is ignored
        {pin_cfg, tied} <= 2'h0;
        apb(1'b1, 8'h10, 32'h1);
        chk("unmapped", 1, slv);
        apb(1'b1, CTRL_OFFSET, 32'h44);
        apb(1'b0, CTRL_OFFSET, 0);
        chk("ctrl", 32'h44, q);
        warn <= 1'b1;
        cyc(4);
        chk("warn report", 0, ind_oen);
        apb(1'b1, CTRL_OFFSET, 32'h04);
        apb(1'b0, STATUS_OFFSET, 0);
        chk("warn flag", 2'h3, {q[ST_OTW_BIT], ind_oen});
        warn <= 1'b0;
        cyc(4);
        apb(1'b0, STATUS_OFFSET, 0);
        chk("warn gone", 0, q[ST_OTW_BIT]);
        thermal_shutdown_flag <= 1'b1;
        cyc(4);
        chk("shutdown", 0, {ind_oen, cp_en, gate_out});
        thermal_shutdown_flag <= 1'b0;
        cyc(4);
        apb(1'b0, STATUS_OFFSET, 0);
        chk("tsd resume", 9'h1ff, {q[ST_TSD_BIT], ind_oen, cp_en, gate_out});
        $display("thermal done");
        stuck <= 6'h01;
        cyc(420);
        apb(1'b0, STATUS_OFFSET, 0);
        chk("gate fault", 2'h1, {ind_oen, q[ST_GDF_BIT]});
        chk("gdf gates", 0, gate_out);
        stuck <= 6'h00;
        pulse <= 1'b1;
        @(posedge clock);
        pulse <= 1'b0;
        cyc(12);
        chk("pulse clear", 7'h7f, {ind_oen, gate_out});
        apb(1'b1, CTRL_OFFSET, 32'h24);
        stuck <= 6'h01;
        cyc(420);
        chk("gdf disabled", 7'h7f, {ind_oen, gate_out});
        stuck <= 6'h00;
        $display("gate fault done");
        go <= 1'b0;
        cyc(DOZE - 8);
        chk("down ind", 0, ind_oen);
        cyc(20);
        chk("sleep", 0, {reg_en, sp_en, cp_en, gate_out});
        go <= 1'b1;
        wait_ready;
        chk("rewake", 3'h7, {reg_en, sp_en, cp_en});
        $display("sleep done");
        finish_test;
    end
endmodule : gate_driver_fault_supervisor_test
`default_nettype wire
